// file: hdl/fibre_pkg.sv
// What this block does
// - Four fibre outputs, each independently selected
// - Five modes: off, A, fallback, B, square
// - Off drives inactive; off is default
// - Mode A: 200 ms pulse only when synchronized
// - Fallback: 200 ms synced, else 1 us local
// - Mode B: 200 ms pulse only when synchronized
// - Square mode: 625 kHz, equal high/low
// - Mode writes refused until password accepted
// - Chosen modes pend until commit accepted
// - New mode applies at next pulse boundary
// - Mode changes disturb no other output
`default_nettype none
package fibre_pkg;
  // ***************************************************************
  // Modes
  // ***************************************************************
  typedef enum logic [2:0] {
    MODE_OFF      = 3'b000,
    MODE_GPS_A    = 3'b001,
    MODE_FALLBACK = 3'b010,
    MODE_GPS_B    = 3'b011,
    MODE_SQUARE   = 3'b100
  } mode_t;

  localparam int NUM_OUTPUTS = 4;
  localparam int MODE_W      = 3;

  typedef struct packed {
    mode_t [NUM_OUTPUTS-1:0] mode;
  } fibre_cfg_t;

  // ***************************************************************
  // Register map (byte addresses)
  // ***************************************************************
  localparam logic [3:0] OFS_UNLOCK = 4'h0;
  localparam logic [3:0] OFS_PEND   = 4'h4;
  localparam logic [3:0] OFS_COMMIT = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;
  localparam int UNLOCK_BIT    = 0;
  localparam int COMMIT_BIT    = 0;
  localparam int DEFAULTS_BIT  = 1;
  localparam int STAT_ACT_POS  = 0;
  localparam int STAT_SYNC_BIT = 12;
  localparam int STAT_UNL_BIT  = 13;
  localparam int STAT_OUT_POS  = 16;
  localparam logic [15:0] UNLOCK_KEY_DEFAULT = 16'hA5A5; // Arbitrary value
  localparam fibre_cfg_t CFG_RESET = '{mode: {NUM_OUTPUTS{MODE_OFF}}};

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam longint CLK_HZ      = 40_000_000;
  localparam longint PULSE_MS    = 200;
  localparam longint LOCAL_US    = 1;
  localparam longint SQUARE_HZ   = 625_000;
  localparam int     PULSE_CYC   = int'(CLK_HZ / 1000 * PULSE_MS);
  localparam int     LOCAL_CYC   = int'(CLK_HZ / 1_000_000 * LOCAL_US);
  localparam int     SQ_HALF_CYC = int'(CLK_HZ / (2 * SQUARE_HZ));
  localparam int     CNT_W       = 24;
endpackage : fibre_pkg
`default_nettype wire

// file: hdl/fibre_pulse_output_selector.sv
`default_nettype none
module fibre_pulse_output_selector
  import fibre_pkg::*;
#(
  parameter int          PULSE_CYCLES = PULSE_CYC,         // Long pulse width in clocks
  parameter logic [15:0] UNLOCK_KEY   = UNLOCK_KEY_DEFAULT  // Level-1 key, arbitrary value
) (
  input  wire logic                   clk,            // 40 MHz clock
  input  wire logic                   rst_n,          // Async reset, active low
  input  wire logic [3:0]             address,        // Avalon byte address
  input  wire logic                   read,           // Avalon read
  input  wire logic                   write,          // Avalon write
  input  wire logic [3:0]             byteenable,     // Avalon byte lanes
  input  wire logic [31:0]            writedata,      // Avalon write data
  output logic [31:0]                 readdata,       // Avalon read data
  output logic                        waitrequest,    // Avalon stall
  input  wire logic                   ppsTick,        // Local one-second tick pin
  input  wire logic                   syncLocked,     // Receiver synchronized pin
  output logic [NUM_OUTPUTS-1:0]      fibreOut        // Fibre driver outputs, high = light
);

  // ***************************************************************
  // Tick synchroniser
  // ***************************************************************
  // Three flops: the first may go metastable, a level counts only
  // once the second and third agree, so one glitch never makes a tick.
  logic [2:0] tickSync_r;
  logic       tickLvl_r;
  wire        tickAgree = (tickSync_r[1] == tickSync_r[2]);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tickSync_r <= 3'h0;
    end else begin
      tickSync_r <= {tickSync_r[1:0], ppsTick};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tickLvl_r <= 1'b0;
    end else if (tickAgree) begin
      tickLvl_r <= tickSync_r[2];
    end
  end

  // Qualified rising edge, one cycle wide; the level resets to the
  // idle level of the pin so no false tick follows reset.
  wire tickRise = tickAgree && tickSync_r[2] && !tickLvl_r;

  // ***************************************************************
  // Lock synchroniser
  // ***************************************************************
  // Sync status follows the pin with about four cycles of lag.
  logic [2:0] lockSync_r;
  logic       lockLvl_r;
  wire        lockAgree = (lockSync_r[1] == lockSync_r[2]);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lockSync_r <= 3'h0;
    end else begin
      lockSync_r <= {lockSync_r[1:0], syncLocked};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lockLvl_r <= 1'b0;
    end else if (lockAgree) begin
      lockLvl_r <= lockSync_r[2];
    end
  end

  wire synced = lockLvl_r;

  // ***************************************************************
  // Bus handshake
  // ***************************************************************
  // One wait cycle: the first cycle of every access stalls while the
  // read mux is captured, the second completes it.
  // Back-to-back accesses are allowed; each takes two cycles.
  logic ack_r;
  wire  access    = read || write;
  wire  accessNew = access && !ack_r;
  wire  doWrite   = write && ack_r;

  assign waitrequest = accessNew;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= accessNew;
    end
  end

  // ***************************************************************
  // Address decode
  // ***************************************************************
  // Decode is purely combinational; only the registers below hold state.
  logic unlocked_r;
  wire  selUnlock  = (address == OFS_UNLOCK);
  wire  selPend    = (address == OFS_PEND);
  wire  selCommit  = (address == OFS_COMMIT);
  wire  selStatus  = (address == OFS_STATUS);
  wire  keyMatch   = (byteenable[1:0] == 2'b11) && (writedata[15:0] == UNLOCK_KEY);
  wire  unlockWr   = doWrite && selUnlock;
  wire  pendWr     = doWrite && selPend && unlocked_r;
  wire  commitWr   = doWrite && selCommit && byteenable[0] && writedata[COMMIT_BIT];
  // Restoring defaults only rewrites the pending set; it still needs a commit.
  wire  defaultsWr = doWrite && selCommit && byteenable[0] && unlocked_r
                     && writedata[DEFAULTS_BIT];

  // Any write to the unlock offset relocks unless it carries the key.
  // The unlock bit is what gates every pending write.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unlocked_r <= 1'b0;
    end else if (unlockWr) begin
      unlocked_r <= keyMatch;
    end
  end

  // ***************************************************************
  // Pending modes
  // ***************************************************************
  fibre_cfg_t  pendNxt;
  fibre_cfg_t  pend_r;
  logic [11:0] pendOld;
  logic [11:0] pendMix;

  // Lane 0 carries bits 7:0, lane 1 bits 11:8; other lanes are ignored.
  assign pendOld       = pend_r;
  assign pendMix[7:0]  = byteenable[0] ? writedata[7:0]  : pendOld[7:0];
  assign pendMix[11:8] = byteenable[1] ? writedata[11:8] : pendOld[11:8];
  assign pendNxt       = fibre_cfg_t'(pendMix);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= CFG_RESET;
    end else if (defaultsWr) begin
      pend_r <= CFG_RESET;
    end else if (pendWr) begin
      pend_r <= pendNxt;
    end
  end

  // ***************************************************************
  // Read path
  // ***************************************************************
  fibre_cfg_t  act_r;
  logic [31:0] statusWord;
  logic [31:0] rdMux;

  assign statusWord[STAT_ACT_POS +: 12]          = act_r;
  assign statusWord[STAT_SYNC_BIT]               = synced;
  assign statusWord[STAT_UNL_BIT]                = unlocked_r;
  assign statusWord[15:14]                       = 2'b00;
  assign statusWord[STAT_OUT_POS +: NUM_OUTPUTS] = fibreOut;
  assign statusWord[31:20]                       = 12'h000;

  // Data is captured in the stall cycle so that it already stands at the
  // edge where the master sees waitrequest low.
  // Write-only and unmapped offsets read as zero.
  assign rdMux = selUnlock ? {31'h0000_0000, unlocked_r} :
                 selPend   ? {20'h00000, pend_r} :
                 selStatus ? statusWord : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
    end else if (read && accessNew) begin
      readdata <= rdMux;
    end
  end

  // ***************************************************************
  // Shared square wave timebase
  // ***************************************************************
  // One timebase for all outputs: every output in test mode shows the
  // same phase, at the cost of a start deferred to a low half.
  // The half period is a whole number of clocks at this clock rate.
  localparam int SQ_W = $clog2(SQ_HALF_CYC);
  logic [SQ_W-1:0] sqCnt_r;
  logic            sqWave_r;
  wire             sqWrap = (sqCnt_r == SQ_W'(SQ_HALF_CYC - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sqCnt_r <= '0;
    end else if (sqWrap) begin
      sqCnt_r <= '0;
    end else begin
      sqCnt_r <= sqCnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sqWave_r <= 1'b0;
    end else if (sqWrap) begin
      sqWave_r <= !sqWave_r;
    end
  end

  // ***************************************************************
  // Per-output mode application and pulse generation
  // ***************************************************************
  logic [NUM_OUTPUTS-1:0] applyReq_r;
  logic [NUM_OUTPUTS-1:0] applyNow;
  logic [NUM_OUTPUTS-1:0] pulseOn;
  logic [CNT_W-1:0]       pulseCnt_r [NUM_OUTPUTS];

  // Each output has private state, so committing one output never
  // touches the timing of another or of anything else on the tick.
  for (genvar i = 0; i < NUM_OUTPUTS; i++) begin : g_out
    mode_t            curMode;
    logic             isOff;
    logic             isSquare;
    logic             syncOnly;
    logic             busy;
    logic [CNT_W-1:0] startWidth;

    assign curMode    = act_r.mode[i];
    assign isOff      = (curMode == MODE_OFF);
    assign isSquare   = (curMode == MODE_SQUARE);
    assign syncOnly   = (curMode == MODE_GPS_A) || (curMode == MODE_GPS_B);
    assign pulseOn[i] = (pulseCnt_r[i] != '0);

    // Boundary: no pulse running and the shared square wave in its low
    // half, so a change never shortens a pulse or a square half.
    assign busy        = pulseOn[i] || sqWave_r;
    assign applyNow[i] = applyReq_r[i] && !busy && !tickRise;

    // The count is fixed at the tick; a later sync loss cuts only the mode A and B output.
    // Codes 5 to 7 get no width, so they stay dark like off.
    always_comb begin
      case (curMode)
        MODE_GPS_A,
        MODE_GPS_B:    startWidth = synced ? CNT_W'(PULSE_CYCLES) : '0;
        MODE_FALLBACK: startWidth = synced ? CNT_W'(PULSE_CYCLES)
                                           : CNT_W'(LOCAL_CYC);
        MODE_OFF:      startWidth = '0;
        MODE_SQUARE:   startWidth = '0;
        default:       startWidth = '0;
      endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        pulseCnt_r[i] <= '0;
      end else if (tickRise) begin
        pulseCnt_r[i] <= startWidth;
      end else if (pulseOn[i]) begin
        pulseCnt_r[i] <= pulseCnt_r[i] - 1'b1;
      end
    end

    // A sync-only pulse is cut as soon as sync is lost.
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        fibreOut[i] <= 1'b0;
      end else if (isOff) begin
        fibreOut[i] <= 1'b0;
      end else if (isSquare) begin
        fibreOut[i] <= sqWave_r;
      end else begin
        fibreOut[i] <= pulseOn[i] && !(syncOnly && !synced);
      end
    end
  end

  // ***************************************************************
  // Commit of pending modes
  // ***************************************************************
  // Commit reaches every output at once; each output then takes its new
  // mode at its own next boundary.
  wire [NUM_OUTPUTS-1:0] commitAll = {NUM_OUTPUTS{commitWr}};

  // A commit in the same cycle as an apply keeps the request alive.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      applyReq_r <= '0;
    end else begin
      applyReq_r <= (applyReq_r & ~applyNow) | commitAll;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_r <= CFG_RESET;
    end else begin
      for (int j = 0; j < NUM_OUTPUTS; j++) begin
        if (applyNow[j]) begin
          act_r.mode[j] <= pend_r.mode[j];
        end
      end
    end
  end

endmodule : fibre_pulse_output_selector
`default_nettype wire

// file: tb/fibre_sel_checker.sv
`default_nettype none
module fibre_sel_checker
  import fibre_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC // Long pulse width in clocks
) (
  input wire logic                   clk,         // Clock
  input wire logic                   rst_n,       // Async reset, active low
  input wire logic [3:0]             address,     // Byte address
  input wire logic                   read,        // Read strobe
  input wire logic                   write,       // Write strobe
  input wire logic [3:0]             byteenable,  // Byte lanes
  input wire logic [31:0]            writedata,   // Write data
  input wire logic [31:0]            readdata,    // Read data
  input wire logic                   waitrequest, // Stall
  input wire logic                   ppsTick,     // Local tick
  input wire logic                   syncLocked,  // Synchronized
  input wire logic [NUM_OUTPUTS-1:0] fibreOut     // Fibre outputs
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****************************************
  // Bus handshake
  // ****************************************
  sequence s_stall;
    (read || write) && waitrequest;
  endsequence
  a_wait_first: assert property ($rose(read || write) |-> waitrequest)
    else $error("access not stalled first cycle");
  a_wait_once: assert property (s_stall |=> !waitrequest)
    else $error("stall longer than one cycle");
  a_wait_idle: assert property (!(read || write) |-> !waitrequest)
    else $error("stall with no access");
  a_zero_reads: assert property (read && !waitrequest
    && (address == OFS_COMMIT || address[1:0] != 2'h0) |-> readdata == 32'h0)
    else $error("write-only or unmapped read not zero");
  a_unlock_bits: assert property (read && !waitrequest && address == OFS_UNLOCK
    |-> readdata[31:1] == 31'h0) else $error("unlock read upper bits set");
  a_status_rsvd: assert property (read && !waitrequest && address == OFS_STATUS
    |-> readdata[15:14] == 2'h0 && readdata[31:20] == 12'h0)
    else $error("status reserved bits set");
  // ****************************************
  // Pulse widths, judged only while sync is steady
  // ****************************************
  logic syncPrev_r;
  int   syncAge_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncPrev_r <= 1'b0;
      syncAge_r  <= 0;
    end else begin
      syncPrev_r <= syncLocked;
      syncAge_r  <= (syncLocked != syncPrev_r) ? 0 : syncAge_r + 1;
    end
  end
  for (genvar i = 0; i < NUM_OUTPUTS; i++) begin : g_out
    int run_r;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) run_r <= 0;
      else run_r <= fibreOut[i] ? run_r + 1 : 0;
    end
    a_width_sync: assert property ($fell(fibreOut[i]) && syncLocked && syncAge_r > run_r + 8
      |-> run_r == SQ_HALF_CYC || run_r == PULSE_CYCLES) else $error("bad synced width");
    a_width_unsync: assert property ($fell(fibreOut[i]) && !syncLocked && syncAge_r > run_r + 8
      |-> run_r == SQ_HALF_CYC || run_r == LOCAL_CYC) else $error("bad unsynced width");
  end
endmodule : fibre_sel_checker
`default_nettype wire

// file: tb/fibre_rx_model.sv
`default_nettype none
module fibre_rx_model
  import fibre_pkg::*;
(
  input  wire logic                   clk,                   // Clock
  input  wire logic                   clr,                   // Forget widths
  input  wire logic [NUM_OUTPUTS-1:0] fibreOut,              // Light per fibre
  output var  int                     lastWidth[NUM_OUTPUTS] // Last pulse width
);
  timeunit 1ns;
  timeprecision 1ps;
  int run[NUM_OUTPUTS];
  // Receivers only time the light, in clock cycles
  always @(posedge clk) begin
    for (int i = 0; i < NUM_OUTPUTS; i++) begin
      run[i] <= fibreOut[i] ? run[i] + 1 : 0;
      if (clr) lastWidth[i] <= 0;
      else if (!fibreOut[i] && run[i] > 0) lastWidth[i] <= run[i];
    end
  end
endmodule : fibre_rx_model
`default_nettype wire

// file: tb/tb_top.sv
`default_nettype none
`define CHK(n, e, g) begin testsRun++; if ((g) !== (e)) begin failCount++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fibre_pkg::*;
  localparam int PC = 100;
  logic clk = 0, rst_n = 0, read = 0, write = 0, ppsTick = 0, syncLocked = 0, clr = 0;
  logic [3:0] address = 4'h0, byteenable = 4'h0;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic waitrequest;
  logic [NUM_OUTPUTS-1:0] fibreOut;
  logic [11:0] cur, nxt;
  int lastWidth[NUM_OUTPUTS];
  int failCount = 0, testsRun = 0, cyc = 0;
  always #12.5 clk = ~clk;
  fibre_pulse_output_selector #(.PULSE_CYCLES(PC)) i_fibre_pulse_output_selector (
    .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .ppsTick(ppsTick), .syncLocked(syncLocked), .fibreOut(fibreOut));
  fibre_rx_model i_fibre_rx_model (.clk(clk), .clr(clr), .fibreOut(fibreOut),
    .lastWidth(lastWidth));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic final_report();
    $display("compares %0d mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failCount++;
      final_report();
    end
  end
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    byteenable <= 4'hF;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic tick();
    @(posedge clk);
    ppsTick <= 1'b1;
    clr <= 1'b1;
    repeat (8) @(posedge clk);
    ppsTick <= 1'b0;
    clr <= 1'b0;
  endtask : tick
  // First rounds cover every mode, later ones are random
  task automatic mk(input int r);
    for (int i = 0; i < NUM_OUTPUTS; i++)
      nxt[3*i +: 3] = 3'((r < 3) ? (r * 3 + i) % 5 : $urandom_range(4));
  endtask : mk
  function automatic int ew(input logic [2:0] m, input logic s);
    case (m)
      3'h1, 3'h3: return s ? PC : 0;
      3'h2: return s ? PC : LOCAL_CYC;
      3'h4: return SQ_HALF_CYC;
      default: return 0;
    endcase
  endfunction : ew
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(43));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, OFS_STATUS, 0);
    `CHK("status", 32'h0, q)
    bus(0, 4'h2, 0);
    `CHK("unmapped", 32'h0, q)
    bus(1, OFS_PEND, 32'($urandom_range(1, 12'hFFF)));
    bus(0, OFS_PEND, 0);
    `CHK("locked", 32'h0, q)
    bus(1, OFS_UNLOCK, 32'(UNLOCK_KEY_DEFAULT));
    bus(0, OFS_UNLOCK, 0);
    `CHK("unlock", 32'h1, q)
    mk(0);
    bus(1, OFS_PEND, {20'h0, nxt});
    bus(1, OFS_COMMIT, 32'h1);
    for (int r = 0; r < 6; r++) begin
      cur = nxt;
      syncLocked <= (r % 3 != 2);
      repeat (80) @(posedge clk);
      bus(0, OFS_STATUS, 0);
      `CHK("active", cur, q[11:0])
      tick();
      repeat (140) @(posedge clk);
      for (int i = 0; i < NUM_OUTPUTS; i++)
        `CHK("width", ew(cur[3*i +: 3], syncLocked), lastWidth[i])
      mk(r + 1);
      bus(1, OFS_PEND, {20'h0, nxt});
      bus(0, OFS_STATUS, 0);
      `CHK("held", cur, q[11:0])
      bus(1, OFS_COMMIT, 32'h1);
      $display("round %0d done", r);
    end
    bus(1, OFS_UNLOCK, 32'h0);
    bus(1, OFS_PEND, 32'h0);
    bus(1, OFS_COMMIT, 32'h2);
    bus(0, OFS_PEND, 0);
    `CHK("relock", {20'h0, nxt}, q)
    bus(1, OFS_UNLOCK, 32'(UNLOCK_KEY_DEFAULT));
    bus(1, OFS_COMMIT, 32'h2);
    bus(1, OFS_COMMIT, 32'h1);
    repeat (80) @(posedge clk);
    bus(0, OFS_STATUS, 0);
    `CHK("defaults", 12'h0, q[11:0])
    $display("defaults done");
    final_report();
  end
endmodule : tb_top
bind fibre_pulse_output_selector fibre_sel_checker #(.PULSE_CYCLES(PULSE_CYCLES)) i_chk (
  .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
  .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .ppsTick(ppsTick), .syncLocked(syncLocked), .fibreOut(fibreOut));
`default_nettype wire
